// File: include/rtc_alarm_map.svh
`ifndef RTC_ALARM_MAP_SVH
`define RTC_ALARM_MAP_SVH

// ****************************************
// Register byte addresses
// ****************************************
`define CTRL_ADDR         8'h00
`define IRQ_STATUS_ADDR   8'h04
`define IRQ_MASK_ADDR     8'h08

// ****************************************
// Control register field positions
// ****************************************
`define ALARM_EN_BIT      31
`define REPEAT_WRAP_BIT   30
`define MASK_MSB          27
`define MASK_LSB          24
`define REPEAT_MSB        23
`define REPEAT_LSB        16
`define UNIT_EN_BIT       15
`define WRITE_LOCK_BIT    11
`define OUT_EN_BIT        7
`define OUT_SEL_MSB       6
`define OUT_SEL_LSB       4

// ****************************************
// Interrupt status bits and reset values
// ****************************************
`define IRQ_ALARM_BIT     0
`define IRQ_LAST_BIT      1
`define CTRL_RESET        32'h0000_0000
`define IRQ_RESET         2'h0
`define REPEAT_MAX        8'hff
`define REPEAT_ZERO       8'h00

`endif

// File: include/rtc_alarm_pkg.sv
package rtc_alarm_pkg;

   // Alarm interval codes; 1010 to 1111 are never to be written
   typedef enum logic [3:0]
   {
      every_half_second = 4'h0,
      every_second      = 4'h1,
      every_ten_seconds = 4'h2,
      every_minute      = 4'h3,
      every_ten_minutes = 4'h4,
      every_hour        = 4'h5,
      every_day         = 4'h6,
      every_week        = 4'h7,
      every_month       = 4'h8,
      every_year        = 4'h9
   } interval_type;

   // Signals that may be routed to the clock output pin
   typedef enum logic [2:0]
   {
      out_alarm_pulse = 3'h0,
      out_seconds     = 3'h1,
      out_half_tick   = 3'h2
   } out_select_type;

endpackage

// File: src/alarm_match.sv
// ****************************************
// Alarm compare, one level per interval
// ****************************************
module alarm_match
   import rtc_alarm_pkg::*;
(
   input  wire logic [3:0] interval_code,
   input  wire logic       cur_half,
   input  wire logic [3:0] cur_sec_ones,
   input  wire logic [2:0] cur_sec_tens,
   input  wire logic [3:0] cur_min_ones,
   input  wire logic [2:0] cur_min_tens,
   input  wire logic [5:0] cur_hour,
   input  wire logic [2:0] cur_weekday,
   input  wire logic [5:0] cur_day,
   input  wire logic [4:0] cur_month,
   input  wire logic       alm_half,
   input  wire logic [3:0] alm_sec_ones,
   input  wire logic [2:0] alm_sec_tens,
   input  wire logic [3:0] alm_min_ones,
   input  wire logic [2:0] alm_min_tens,
   input  wire logic [5:0] alm_hour,
   input  wire logic [2:0] alm_weekday,
   input  wire logic [5:0] alm_day,
   input  wire logic [4:0] alm_month,
   output wire logic       match
);

   wire logic        lvl1;
   wire logic        lvl2;
   wire logic        lvl3;
   wire logic        lvl4;
   wire logic        lvl5;
   wire logic        lvl6;
   wire logic        lvl7;
   wire logic        lvl8;
   wire logic        lvl9;
   wire logic [15:0] level_table;

   // short intervals widen the compare field by field
   assign lvl1 = cur_half == alm_half;
   assign lvl2 = lvl1 && cur_sec_ones == alm_sec_ones;
   assign lvl3 = lvl2 && cur_sec_tens == alm_sec_tens;
   assign lvl4 = lvl3 && cur_min_ones == alm_min_ones;
   assign lvl5 = lvl4 && cur_min_tens == alm_min_tens;
   assign lvl6 = lvl5 && cur_hour == alm_hour;
   // day, week, month and year compares
   assign lvl7 = lvl6 && cur_weekday == alm_weekday;
   assign lvl8 = lvl6 && cur_day == alm_day;
   // A 29 February alarm only meets a matching date in leap years
   assign lvl9 = lvl8 && cur_month == alm_month;

   // Reserved codes never match
   assign level_table = {6'h00, lvl9, lvl8, lvl7, lvl6, lvl5, lvl4, lvl3, lvl2, lvl1, 1'b1};
   assign match       = level_table[interval_code];

endmodule // alarm_match

// File: src/rtc_alarm_control.sv
`include "rtc_alarm_map.svh"

module rtc_alarm_control
   import rtc_alarm_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   output      logic [31:0] reg_rdata,
   input  wire logic        sys_unlocked,
   input  wire logic        half_tick,
   input  wire logic        cur_half,
   input  wire logic [3:0]  cur_sec_ones,
   input  wire logic [2:0]  cur_sec_tens,
   input  wire logic [3:0]  cur_min_ones,
   input  wire logic [2:0]  cur_min_tens,
   input  wire logic [5:0]  cur_hour,
   input  wire logic [2:0]  cur_weekday,
   input  wire logic [5:0]  cur_day,
   input  wire logic [4:0]  cur_month,
   input  wire logic        alm_half,
   input  wire logic [3:0]  alm_sec_ones,
   input  wire logic [2:0]  alm_sec_tens,
   input  wire logic [3:0]  alm_min_ones,
   input  wire logic [2:0]  alm_min_tens,
   input  wire logic [5:0]  alm_hour,
   input  wire logic [2:0]  alm_weekday,
   input  wire logic [5:0]  alm_day,
   input  wire logic [4:0]  alm_month,
   output      logic        unit_run,
   output      logic        alarm_pulse,
   output      logic        clock_out,
   output      logic        clock_out_oe,
   output      logic        irq
);

   // ****************************************
   // Control and status state
   // ****************************************
   logic        alarm_enable_reg;
   logic        repeat_wrap_reg;
   logic [3:0]  alarm_interval_mask_reg;
   logic [7:0]  alarm_repeat_count_reg;
   logic        unit_enable_reg;
   logic        time_write_lock_reg;
   logic        clock_output_enable_reg;
   logic [2:0]  clock_output_select_reg;
   logic [1:0]  irq_status_reg;
   logic [1:0]  irq_mask_reg;

   logic        alarm_enable_next;
   logic [7:0]  alarm_repeat_count_next;
   logic        time_write_lock_next;
   logic [1:0]  irq_status_next;
   logic [1:0]  irq_mask_next;

   wire logic        ctrl_write;
   wire logic        status_write;
   wire logic        mask_write;
   wire logic        match;
   wire logic        alarm_event;
   wire logic        last_event;
   wire logic [7:0]  repeat_after_event;
   wire logic [1:0]  event_bits;
   wire logic [31:0] ctrl_view;
   wire logic [31:0] read_mux;
   wire logic [7:0]  out_sources;

   // ****************************************
   // Register decode
   // ****************************************
   assign ctrl_write   = reg_write && reg_addr == `CTRL_ADDR;
   assign status_write = reg_write && reg_addr == `IRQ_STATUS_ADDR;
   assign mask_write   = reg_write && reg_addr == `IRQ_MASK_ADDR;

   alarm_match u_match
   (
      .interval_code (alarm_interval_mask_reg),
      .cur_half      (cur_half),
      .cur_sec_ones  (cur_sec_ones),
      .cur_sec_tens  (cur_sec_tens),
      .cur_min_ones  (cur_min_ones),
      .cur_min_tens  (cur_min_tens),
      .cur_hour      (cur_hour),
      .cur_weekday   (cur_weekday),
      .cur_day       (cur_day),
      .cur_month     (cur_month),
      .alm_half      (alm_half),
      .alm_sec_ones  (alm_sec_ones),
      .alm_sec_tens  (alm_sec_tens),
      .alm_min_ones  (alm_min_ones),
      .alm_min_tens  (alm_min_tens),
      .alm_hour      (alm_hour),
      .alm_weekday   (alm_weekday),
      .alm_day       (alm_day),
      .alm_month     (alm_month),
      .match         (match)
   );

   // ****************************************
   // Alarm event and repeat count
   // ****************************************
   // compare only on the half-second step of a running unit
   assign alarm_event = unit_enable_reg && alarm_enable_reg && half_tick && match;
   // the alarm with no repeats left and wrap off is the last one
   assign last_event  = alarm_event && alarm_repeat_count_reg == `REPEAT_ZERO && !repeat_wrap_reg;

   // wrap from 00 to ff when allowed
   assign repeat_after_event = (alarm_repeat_count_reg != `REPEAT_ZERO) ? alarm_repeat_count_reg - 8'h01 :
                               repeat_wrap_reg ? `REPEAT_MAX : `REPEAT_ZERO;

   // A software write in the same cycle as an event takes precedence over the count step
   always_comb
   begin
      alarm_repeat_count_next = alarm_repeat_count_reg;
      alarm_enable_next       = alarm_enable_reg;
      if (ctrl_write)
      begin
         alarm_repeat_count_next = reg_wdata[`REPEAT_MSB:`REPEAT_LSB];
         alarm_enable_next       = reg_wdata[`ALARM_EN_BIT];
      end
      else if (alarm_event)
      begin
         alarm_repeat_count_next = repeat_after_event;
         // N repeats used up: the alarm switches itself off
         if (last_event)
            alarm_enable_next = 1'b0;
      end
   end

   // lock may always be set, cleared only after the unlock
   always_comb
   begin
      time_write_lock_next = time_write_lock_reg;
      if (ctrl_write)
      begin
         if (reg_wdata[`WRITE_LOCK_BIT])
            time_write_lock_next = 1'b1;
         else if (sys_unlocked)
            time_write_lock_next = 1'b0;
      end
   end

   // ****************************************
   // Interrupt status and mask
   // ****************************************
   assign event_bits = {last_event, alarm_event};

   // New events win over a write-one-to-clear in the same cycle
   always_comb
   begin
      irq_status_next = irq_status_reg;
      if (status_write)
         irq_status_next = irq_status_reg & ~reg_wdata[1:0];
      irq_status_next = irq_status_next | event_bits;
      irq_mask_next   = mask_write ? reg_wdata[1:0] : irq_mask_reg;
   end

   // ****************************************
   // Control register flops
   // ****************************************
   always_ff @(posedge clk)
   begin
      // all control fields clear on reset
      if (sys_rst)
      begin
         alarm_enable_reg        <= 1'b0;
         repeat_wrap_reg         <= 1'b0;
         alarm_interval_mask_reg <= 4'h0;
         alarm_repeat_count_reg  <= `REPEAT_ZERO;
         unit_enable_reg         <= 1'b0;
         time_write_lock_reg     <= 1'b0;
         clock_output_enable_reg <= 1'b0;
         clock_output_select_reg <= 3'h0;
      end
      else
      begin
         alarm_enable_reg       <= alarm_enable_next;
         alarm_repeat_count_reg <= alarm_repeat_count_next;
         time_write_lock_reg    <= time_write_lock_next;
         if (ctrl_write)
         begin
            // fields taken at their bit positions
            repeat_wrap_reg         <= reg_wdata[`REPEAT_WRAP_BIT];
            alarm_interval_mask_reg <= reg_wdata[`MASK_MSB:`MASK_LSB];
            unit_enable_reg         <= reg_wdata[`UNIT_EN_BIT];
            clock_output_enable_reg <= reg_wdata[`OUT_EN_BIT];
            clock_output_select_reg <= reg_wdata[`OUT_SEL_MSB:`OUT_SEL_LSB];
         end
      end
   end

   // ****************************************
   // Read path
   // ****************************************
   // unimplemented bits stay zero in the view
   assign ctrl_view = {alarm_enable_reg, repeat_wrap_reg, 2'b00, alarm_interval_mask_reg,
                       alarm_repeat_count_reg, unit_enable_reg, 3'b000, time_write_lock_reg,
                       3'b000, clock_output_enable_reg, clock_output_select_reg, 4'h0};

   assign read_mux = (reg_addr == `CTRL_ADDR)       ? ctrl_view :
                     (reg_addr == `IRQ_STATUS_ADDR) ? {30'h0, irq_status_reg} :
                     (reg_addr == `IRQ_MASK_ADDR)   ? {30'h0, irq_mask_reg} : 32'h0;

   // pin sources; unused selections show low
   assign out_sources = {5'h00, half_tick, cur_half, alarm_event};

   // ****************************************
   // Interrupt status, mask and output flops
   // ****************************************
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         reg_rdata      <= `CTRL_RESET;
         irq_status_reg <= `IRQ_RESET;
         irq_mask_reg   <= `IRQ_RESET;
         irq            <= 1'b0;
         unit_run       <= 1'b0;
         alarm_pulse    <= 1'b0;
         clock_out      <= 1'b0;
         clock_out_oe   <= 1'b0;
      end
      else
      begin
         reg_rdata      <= reg_read ? read_mux : 32'h0;
         irq_status_reg <= irq_status_next;
         irq_mask_reg   <= irq_mask_next;
         irq            <= |(irq_status_next & irq_mask_next);
         // the counters run only while enabled
         unit_run       <= ctrl_write ? reg_wdata[`UNIT_EN_BIT] : unit_enable_reg;
         alarm_pulse    <= alarm_event;
         // pin driven only while the output enable is set
         clock_out      <= clock_output_enable_reg && out_sources[clock_output_select_reg];
         clock_out_oe   <= clock_output_enable_reg;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   property p_alarm_gate;
      @(posedge clk) disable iff (sys_rst)
      alarm_pulse |-> $past(alarm_enable_reg) && $past(unit_enable_reg) && $past(half_tick);
   endproperty
   a_alarm_gate: assert property (p_alarm_gate) else $error("alarm without enable");

   property p_wrap;
      @(posedge clk) disable iff (sys_rst)
      alarm_event && !ctrl_write && repeat_wrap_reg && alarm_repeat_count_reg == 8'h00
      |=> alarm_repeat_count_reg == 8'hff && alarm_enable_reg;
   endproperty
   a_wrap: assert property (p_wrap) else $error("repeat count did not wrap");

   property p_hold_zero;
      @(posedge clk) disable iff (sys_rst)
      alarm_event && !ctrl_write && !repeat_wrap_reg && alarm_repeat_count_reg == 8'h00
      |=> alarm_repeat_count_reg == 8'h00 && !alarm_enable_reg;
   endproperty
   a_hold_zero: assert property (p_hold_zero) else $error("repeat count left zero");

   property p_decrement;
      @(posedge clk) disable iff (sys_rst)
      alarm_event && !ctrl_write && alarm_repeat_count_reg != 8'h00
      |=> alarm_repeat_count_reg == $past(alarm_repeat_count_reg) - 8'h01;
   endproperty
   a_decrement: assert property (p_decrement) else $error("repeat count not decremented");

   property p_count_stable;
      @(posedge clk) disable iff (sys_rst)
      !alarm_event && !ctrl_write |=> $stable(alarm_repeat_count_reg);
   endproperty
   a_count_stable: assert property (p_count_stable) else $error("repeat count moved without event");

   property p_half_second;
      @(posedge clk) disable iff (sys_rst)
      unit_enable_reg && alarm_enable_reg && half_tick && alarm_interval_mask_reg == 4'h0 |=> alarm_pulse;
   endproperty
   a_half_second: assert property (p_half_second) else $error("half second alarm missed");

   property p_year;
      @(posedge clk) disable iff (sys_rst)
      alarm_event && alarm_interval_mask_reg == 4'h9 |-> cur_day == alm_day && cur_month == alm_month;
   endproperty
   a_year: assert property (p_year) else $error("yearly alarm on wrong date");

   property p_unit_run;
      @(posedge clk) disable iff (sys_rst)
      ctrl_write |=> unit_run == $past(reg_wdata[15]) ##1 unit_run == unit_enable_reg;
   endproperty
   a_unit_run: assert property (p_unit_run) else $error("unit run does not follow enable");

   property p_lock_hold;
      @(posedge clk) disable iff (sys_rst)
      time_write_lock_reg && !sys_unlocked |=> time_write_lock_reg;
   endproperty
   a_lock_hold: assert property (p_lock_hold) else $error("write lock cleared while locked");

   property p_read_zero;
      @(posedge clk) disable iff (sys_rst)
      reg_read && reg_addr == 8'h00 |=> reg_rdata[29:28] == 2'b00 && reg_rdata[14:12] == 3'b000
                                        && reg_rdata[3:0] == 4'h0;
   endproperty
   a_read_zero: assert property (p_read_zero) else $error("unimplemented bits read nonzero");

   property p_pin_off;
      @(posedge clk) disable iff (sys_rst)
      !clock_out_oe |-> !clock_out;
   endproperty
   a_pin_off: assert property (p_pin_off) else $error("clock pin high while disabled");

endmodule // rtc_alarm_control

// File: sim/testbench.sv
`include "rtc_alarm_map.svh"

module testbench
   import rtc_alarm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [31:0] impl_bits   = 32'hcfff_88f0;
   localparam int          lsb_pos [9] = '{34, 30, 27, 23, 20, 14, 11, 5, 0};

   logic        clk;
   logic        sys_rst;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_write;
   logic        reg_read;
   logic [31:0] reg_rdata;
   logic        sys_unlocked;
   logic        half_tick;
   logic [34:0] cur_v;
   logic [34:0] alm_v;
   logic        unit_run;
   logic        alarm_pulse;
   logic        clock_out;
   logic        clock_out_oe;
   logic        irq;
   logic        seen_pulse;
   logic        seen_out;
   int          miscompares;
   int          n_compared;

   // Time fields packed half, seconds, minutes, hour, weekday, day, month
   rtc_alarm_control i_rtc_alarm_control
   (
      .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .sys_unlocked(sys_unlocked), .half_tick(half_tick),
      .cur_half(cur_v[34]), .cur_sec_ones(cur_v[33:30]), .cur_sec_tens(cur_v[29:27]),
      .cur_min_ones(cur_v[26:23]), .cur_min_tens(cur_v[22:20]), .cur_hour(cur_v[19:14]),
      .cur_weekday(cur_v[13:11]), .cur_day(cur_v[10:5]), .cur_month(cur_v[4:0]),
      .alm_half(alm_v[34]), .alm_sec_ones(alm_v[33:30]), .alm_sec_tens(alm_v[29:27]),
      .alm_min_ones(alm_v[26:23]), .alm_min_tens(alm_v[22:20]), .alm_hour(alm_v[19:14]),
      .alm_weekday(alm_v[13:11]), .alm_day(alm_v[10:5]), .alm_month(alm_v[4:0]),
      .unit_run(unit_run), .alarm_pulse(alarm_pulse), .clock_out(clock_out),
      .clock_out_oe(clock_out_oe), .irq(irq)
   );

   // ****************************************
   // Clock and watchdog
   // ****************************************
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Whole run is well under a thousand cycles; 20000 leaves ample margin
   initial
   begin
      #(40 * 20000);
      miscompares++;
      end_of_test();
   end

   // ****************************************
   // Helpers
   // ****************************************
   task automatic end_of_test();
      $display("Compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
         miscompares++;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_write <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
      @(posedge clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_read <= 1'b0;
      @(negedge clk);
      check(name, reg_rdata, exp);
      @(negedge clk);
      check("rdata_idle", reg_rdata, 32'h0);
   endtask

   // The clock pin outputs need one extra cycle after a write lands; unit_run and irq do not
   task automatic settle();
      repeat (2) @(negedge clk);
   endtask

   task automatic tick();
      @(posedge clk);
      half_tick <= 1'b1;
      @(posedge clk);
      half_tick <= 1'b0;
      @(negedge clk);
      seen_pulse = alarm_pulse;
      seen_out   = clock_out;
      @(negedge clk);
      check("alarm_pulse_width", {31'h0, alarm_pulse}, 32'h0);
   endtask

   function automatic logic [31:0] ctrl_view(input logic [31:0] d);
      return d & impl_bits;
   endfunction

   // Field f was disturbed in the alarm time; fire unless the code compares it
   function automatic logic [31:0] fires(input logic [3:0] code, input int f);
      logic sel;
      sel = 1'b0;
      case (f)
         0, 1, 2, 3, 4, 5: sel = (int'(code) > f);
         6: sel = (code == 4'h7);
         7: sel = (code >= 4'h8);
         8: sel = (code == 4'h9);
         default: sel = 1'b0;
      endcase
      return {31'h0, (code <= 4'h9) && !sel};
   endfunction

   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      logic [31:0] d;
      logic [34:0] t;
      sys_rst = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_write = 1'b0;
      reg_read = 1'b0;
      sys_unlocked = 1'b1;
      half_tick = 1'b0;
      cur_v = 35'h0;
      alm_v = 35'h0;
      miscompares = 0;
      n_compared = 0;
      void'($urandom(32'h8368354c));
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      rd_chk(`CTRL_ADDR, 32'h0, "ctrl_reset");
      rd_chk(`IRQ_STATUS_ADDR, 32'h0, "status_reset");
      rd_chk(`IRQ_MASK_ADDR, 32'h0, "mask_reset");
      check("oe_reset", {31'h0, clock_out_oe}, 32'h0);
      repeat (6)
      begin
         d = $urandom;
         d[27] = 1'b0;
         wr(`CTRL_ADDR, d);
         rd_chk(`CTRL_ADDR, ctrl_view(d), "ctrl_readback");
      end
      wr(8'h0c, 32'hffff_ffff);
      rd_chk(`CTRL_ADDR, ctrl_view(d), "ctrl_after_unmapped");
      rd_chk(8'h0c, 32'h0, "unmapped_read");
      wr(`CTRL_ADDR, 32'h0000_0800);
      @(posedge clk);
      sys_unlocked <= 1'b0;
      wr(`CTRL_ADDR, 32'h0);
      rd_chk(`CTRL_ADDR, 32'h0000_0800, "lock_held");
      @(posedge clk);
      sys_unlocked <= 1'b1;
      wr(`CTRL_ADDR, 32'h0);
      rd_chk(`CTRL_ADDR, 32'h0, "lock_cleared");
      wr(`CTRL_ADDR, 32'h8005_0000);
      settle();
      check("unit_run_off", {31'h0, unit_run}, 32'h0);
      tick();
      check("no_alarm_unit_off", {31'h0, seen_pulse}, 32'h0);
      wr(`CTRL_ADDR, 32'h4005_8000);
      settle();
      check("unit_run_on", {31'h0, unit_run}, 32'h1);
      tick();
      check("no_alarm_disabled", {31'h0, seen_pulse}, 32'h0);
      wr(`CTRL_ADDR, 32'h8002_8000);
      tick();
      check("alarm_first", {31'h0, seen_pulse}, 32'h1);
      rd_chk(`CTRL_ADDR, 32'h8001_8000, "count_dec");
      rd_chk(`IRQ_STATUS_ADDR, 32'h1, "status_event");
      check("irq_masked", {31'h0, irq}, 32'h0);
      wr(`IRQ_MASK_ADDR, 32'h3);
      settle();
      check("irq_unmasked", {31'h0, irq}, 32'h1);
      wr(`IRQ_STATUS_ADDR, 32'h3);
      settle();
      check("irq_cleared", {31'h0, irq}, 32'h0);
      rd_chk(`IRQ_STATUS_ADDR, 32'h0, "status_w1c");
      tick();
      check("alarm_second", {31'h0, seen_pulse}, 32'h1);
      rd_chk(`CTRL_ADDR, 32'h8000_8000, "count_zero");
      tick();
      check("alarm_last", {31'h0, seen_pulse}, 32'h1);
      rd_chk(`CTRL_ADDR, 32'h0000_8000, "count_held");
      rd_chk(`IRQ_STATUS_ADDR, 32'h3, "status_last");
      check("irq_last", {31'h0, irq}, 32'h1);
      tick();
      check("no_alarm_after_last", {31'h0, seen_pulse}, 32'h0);
      wr(`CTRL_ADDR, 32'hc000_8000);
      tick();
      check("alarm_wrap", {31'h0, seen_pulse}, 32'h1);
      rd_chk(`CTRL_ADDR, 32'hc0ff_8000, "count_wrapped");
      wr(`CTRL_ADDR, 32'h0000_8080 | (32'(out_half_tick) << 4));
      settle();
      check("oe_on", {31'h0, clock_out_oe}, 32'h1);
      tick();
      check("pin_tick", {31'h0, seen_out}, 32'h1);
      wr(`CTRL_ADDR, 32'h0000_8020);
      settle();
      check("oe_off", {31'h0, clock_out_oe}, 32'h0);
      tick();
      check("pin_quiet", {31'h0, seen_out}, 32'h0);
      @(posedge clk);
      cur_v <= 35'h4_0000_0000;
      wr(`CTRL_ADDR, 32'h0000_8080 | (32'(out_seconds) << 4));
      settle();
      check("pin_half", {31'h0, clock_out}, 32'h1);
      wr(`CTRL_ADDR, 32'h8000_8080 | (32'(out_alarm_pulse) << 4));
      tick();
      check("pin_alarm", {31'h0, seen_out}, 32'h1);
      // ****************************************
      // Every legal interval code against every field
      // ****************************************
      // reserved codes never written
      for (int c = 0; c < 10; c++)
      begin
         wr(`CTRL_ADDR, 32'hc000_8000 | (32'(c) << 24));
         for (int f = 0; f < 10; f++)
         begin
            t = 35'({$urandom, $urandom});
            @(posedge clk);
            cur_v <= t;
            alm_v <= (f < 9) ? t ^ (35'h1 << lsb_pos[f]) : t;
            tick();
            check("interval_fire", {31'h0, seen_pulse}, fires(4'(c), f));
         end
      end
      @(posedge clk);
      sys_rst <= 1'b1;
      @(posedge clk);
      sys_rst <= 1'b0;
      rd_chk(`CTRL_ADDR, 32'h0, "ctrl_rereset");
      rd_chk(`IRQ_STATUS_ADDR, 32'h0, "status_rereset");
      check("irq_rereset", {31'h0, irq}, 32'h0);
      end_of_test();
   end

endmodule // testbench
